//--- emulated_phy_special.v
/*
 * Emulated PHY special control/status register with the port 0 datapath
 * controls it steers: far loopback, collision test, drive strength, clock
 * direction, double-rate select and heartbeat test enable.
 * Assumes fabric signals run on clk; MAC pins and the link clock come from
 * outside and are synchronised here. Straps are stable at reset release.
 */
// Behaviour
// (R01) Loopback set: fabric port 0 transmit withheld from MAC, fed back as receive.
// (R02) Software sets receive-own-transmit when looping back in half duplex.
// (R03) Loopback works even while the emulated PHY is isolated.
// (R04) Double-rate bit turns the 100 Mbit/s choice into 200 Mbit/s.
// (R05) Drive 16 mA only if bit set in RMII or 200 Mbit/s MII PHY.
// (R06) Mode field reads 00 MII MAC, 01 MII PHY, 10 RMII PHY.
// (R07) Collision test set: collision asserted whenever fabric transmits on port 0.
// (R08) Software uses collision test only together with loopback.
// (R09) Clock direction bit: 0 reference clock pin input, 1 driven output.
// (R10) Speed/duplex reads 001,010,101,110 for 10H,100H,10F,100F.
// (R11) Speed/duplex from autonegotiation when enabled, else from basic control bits.
// (R12) Heartbeat disable bit acts only in MII PHY mode; 1 disables test.
// (R13) Virtual PHY reset with reset bit set restores clock direction and drive.
// (R14) CSR offset 0x1DC, 32 bits, upper half zero; management index 31, 16 bits.
// (R15) Double-rate, mode, clock direction, drive and heartbeat defaults come from straps.
// (R16) Straps captured when chip reset is released.
// (R17) Writes to reserved or read-only bits ignored; reserved bits read zero.
`timescale 1ns/1ps
`include "emulated_phy_special_regs.vh"
`default_nettype none

module emulated_phy_special #(
	parameter DATA_W = 4
) (
	input  wire              clk,
	input  wire              rst_n,
	input  wire              ce,
	// Straps
	input  wire              double_rate_strap,
	input  wire [1:0]        port0_mode_straps,
	input  wire              clock_direction_strap,
	input  wire              clock_drive_strap,
	input  wire              heartbeat_disable_strap,
	// Emulated PHY basic control and autonegotiation result
	input  wire              emulated_phy_isolate,
	input  wire              emulated_autoneg_enable,
	input  wire              emulated_speed_select,
	input  wire              emulated_duplex_mode,
	input  wire              autoneg_speed_100,
	input  wire              autoneg_full_duplex,
	input  wire              emulated_phy_reset_bit,
	input  wire              vphy_reset_pulse,
	// CSR access
	input  wire [11:0]       csr_addr,
	input  wire              csr_wr,
	input  wire              csr_rd,
	input  wire [31:0]       csr_wdata,
	output reg  [31:0]       csr_rdata,
	output reg               csr_rvalid,
	// Management access
	input  wire [4:0]        mgmt_index,
	input  wire              mgmt_wr,
	input  wire              mgmt_rd,
	input  wire [15:0]       mgmt_wdata,
	output reg  [15:0]       mgmt_rdata,
	output reg               mgmt_rvalid,
	// Fabric port 0
	input  wire              fabric_tx_en,
	input  wire [DATA_W-1:0] fabric_txd,
	output reg               fabric_rx_dv,
	output reg  [DATA_W-1:0] fabric_rxd,
	output reg               fabric_col,
	// External MAC pins
	input  wire              link_clk,
	input  wire              mac_tx_en,
	input  wire [DATA_W-1:0] mac_txd,
	output reg               mac_rx_dv,
	output reg  [DATA_W-1:0] mac_rxd,
	// Reference clock pin and pad controls
	input  wire              refclk_in,
	output reg               refclk_out,
	output reg               refclk_oe_n,
	output reg               drive_16ma,
	output reg               rate_200,
	output reg               heartbeat_test_en
);

	// ****************************************************************
	// Register fields
	// ****************************************************************
	reg        loopback;
	reg        double_rate;
	reg [1:0]  port_mode;
	reg        coll_test;
	reg        clk_dir;
	reg        clk_drive;
	reg        heartbeat_test_disable;
	reg [2:0]  speed_duplex;
	reg        strap_pending;
	reg        dir_default;
	reg        drive_default;
	reg  [5:0]  strap_s1;
	reg  [5:0]  strap_s2;
	wire [15:0] reg_value;
	wire        csr_hit;
	wire        mgmt_hit;
	wire        wr_any;
	wire [15:0] wr_data;
	reg  [2:0]  next_speed_duplex;

	function [2:0] spd_code;
		input fast;
		input full;
		begin
			spd_code = {full, fast, ~fast};
		end
	endfunction

	assign csr_hit  = (csr_addr == `SPECIAL_CSR_OFFSET); // R14
	assign mgmt_hit = (mgmt_index == `SPECIAL_MII_INDEX); // R14
	assign wr_any   = (csr_wr & csr_hit) | (mgmt_wr & mgmt_hit);
	// CSR wins when both ports write in one cycle
	assign wr_data  = (csr_wr & csr_hit) ? csr_wdata[15:0] : mgmt_wdata;

	assign reg_value = {1'b0, loopback, 3'b000, double_rate, port_mode, coll_test,
		clk_dir, clk_drive, speed_duplex, 1'b0, heartbeat_test_disable}; // R06 R17

	always @* begin
		if (emulated_autoneg_enable) begin
			next_speed_duplex = spd_code(autoneg_speed_100, autoneg_full_duplex); // R11
		end else begin
			next_speed_duplex = spd_code(emulated_speed_select, emulated_duplex_mode); // R11
		end
	end

	// Strap pins pass two stages; no reset, so the second stage already
	// holds the settled levels when reset lets go
	always @(posedge clk) begin
		if (ce) begin
			strap_s1 <= {double_rate_strap, port0_mode_straps, clock_direction_strap,
				clock_drive_strap, heartbeat_disable_strap};
			strap_s2 <= strap_s1;
		end
	end

	// ****************************************************************
	// Register state
	// ****************************************************************
	// Defaults load on the first enabled cycle after release, so straps
	// are sampled only after they have settled.
	always @(posedge clk) begin
		if (!rst_n) begin
			loopback               <= `LOOPBACK_RESET;
			coll_test              <= `COLL_TEST_RESET;
			double_rate            <= 1'b0;
			port_mode              <= `MODE_MII_MAC;
			clk_dir                <= 1'b0;
			clk_drive              <= 1'b0;
			heartbeat_test_disable <= 1'b0;
			dir_default            <= 1'b0;
			drive_default          <= 1'b0;
			speed_duplex           <= `SPD_10_HALF;
			strap_pending          <= 1'b1;
		end else if (ce) begin
			speed_duplex <= next_speed_duplex; // R10
			if (strap_pending) begin
				strap_pending          <= 1'b0;
				double_rate            <= strap_s2[5]; // R15 R16
				port_mode              <= strap_s2[4:3]; // R15 R16
				clk_dir                <= strap_s2[2]; // R15 R16
				clk_drive              <= strap_s2[1]; // R15 R16
				heartbeat_test_disable <= strap_s2[0]; // R15 R16
				dir_default            <= strap_s2[2];
				drive_default          <= strap_s2[1];
			end else if (vphy_reset_pulse && emulated_phy_reset_bit) begin
				clk_dir   <= dir_default; // R13
				clk_drive <= drive_default; // R13
			end else if (wr_any) begin
				loopback               <= wr_data[`FLD_LOOPBACK]; // R17
				double_rate            <= wr_data[`FLD_DOUBLE_RATE];
				coll_test              <= wr_data[`FLD_COLL_TEST];
				clk_dir                <= wr_data[`FLD_CLK_DIR];
				clk_drive              <= wr_data[`FLD_CLK_DRIVE];
				heartbeat_test_disable <= wr_data[`FLD_HEARTBEAT_OFF];
			end
		end
	end

	// ****************************************************************
	// Read ports
	// ****************************************************************
	always @(posedge clk) begin
		if (!rst_n) begin
			csr_rdata   <= 32'h0000_0000;
			csr_rvalid  <= 1'b0;
			mgmt_rdata  <= 16'h0000;
			mgmt_rvalid <= 1'b0;
		end else if (ce) begin
			csr_rvalid  <= csr_rd;
			mgmt_rvalid <= mgmt_rd;
			// Unmapped offsets read as zero
			csr_rdata   <= (csr_rd && csr_hit) ? {16'h0000, reg_value} : 32'h0000_0000; // R14
			mgmt_rdata  <= (mgmt_rd && mgmt_hit) ? reg_value : 16'h0000; // R14
		end
	end

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	reg [1:0]        lclk_sync;
	reg              lclk_prev;
	reg              mtx_en_s1;
	reg              mtx_en_s2;
	reg [DATA_W-1:0] mtxd_s1;
	reg [DATA_W-1:0] mtxd_s2;
	reg              refclk_s1;
	reg              refclk_s2;
	wire             link_edge;

	assign link_edge = lclk_sync[1] & ~lclk_prev;

	always @(posedge clk) begin
		if (!rst_n) begin
			lclk_sync <= 2'h0;
			lclk_prev <= 1'b0;
			mtx_en_s1 <= 1'b0;
			mtx_en_s2 <= 1'b0;
			mtxd_s1   <= {DATA_W{1'b0}};
			mtxd_s2   <= {DATA_W{1'b0}};
			refclk_s1 <= 1'b0;
			refclk_s2 <= 1'b0;
		end else if (ce) begin
			lclk_sync <= {lclk_sync[0], link_clk};
			lclk_prev <= lclk_sync[1];
			mtx_en_s1 <= mac_tx_en;
			mtx_en_s2 <= mtx_en_s1;
			mtxd_s1   <= mac_txd;
			mtxd_s2   <= mtxd_s1;
			refclk_s1 <= refclk_in;
			refclk_s2 <= refclk_s1;
		end
	end

	// ****************************************************************
	// Port 0 datapath and pad controls
	// ****************************************************************
	// The sampled reference clock input is kept for a future rate detector;
	// here only direction matters.
	wire fast_mode;
	assign fast_mode = double_rate & speed_duplex[1];

	always @(posedge clk) begin
		if (!rst_n) begin
			fabric_rx_dv      <= 1'b0;
			fabric_rxd        <= {DATA_W{1'b0}};
			fabric_col        <= 1'b0;
			mac_rx_dv         <= 1'b0;
			mac_rxd           <= {DATA_W{1'b0}};
			refclk_out        <= 1'b0;
			refclk_oe_n       <= 1'b1;
			drive_16ma        <= 1'b0;
			rate_200          <= 1'b0;
			heartbeat_test_en <= 1'b0;
		end else if (ce) begin
			fabric_col  <= coll_test & fabric_tx_en; // R07
			refclk_out  <= ~refclk_out;
			refclk_oe_n <= ~clk_dir; // R09
			rate_200    <= fast_mode; // R04
			drive_16ma  <= clk_drive & ((port_mode == `MODE_RMII_PHY) |
				((port_mode == `MODE_MII_PHY) & fast_mode)); // R05
			heartbeat_test_en <= (port_mode == `MODE_MII_PHY) & ~heartbeat_test_disable; // R12
			if (loopback) begin
				// Isolate is not consulted here, so loopback survives it
				fabric_rx_dv <= fabric_tx_en; // R01 R03
				fabric_rxd   <= fabric_txd; // R01
				mac_rx_dv    <= 1'b0; // R01
				mac_rxd      <= {DATA_W{1'b0}};
			end else if (link_edge) begin
				fabric_rx_dv <= mtx_en_s2;
				fabric_rxd   <= mtxd_s2;
				mac_rx_dv    <= fabric_tx_en & ~emulated_phy_isolate;
				mac_rxd      <= emulated_phy_isolate ? {DATA_W{1'b0}} : fabric_txd;
			end
		end
	end

endmodule // emulated_phy_special

`default_nettype wire

//--- emulated_phy_special_regs.vh
/*
 * Offsets, field positions, write mask and timing counts of the emulated PHY
 * special control/status register.
 * Assumes it is included by its bare name from design and bench files.
 */
`ifndef EMULATED_PHY_SPECIAL_REGS_VH
`define EMULATED_PHY_SPECIAL_REGS_VH

// ****************************************************************
// Register placement
// ****************************************************************
`define SPECIAL_CSR_OFFSET   12'h1DC
`define SPECIAL_MII_INDEX    5'h1F

// ****************************************************************
// Field positions
// ****************************************************************
`define FLD_LOOPBACK         14
`define FLD_DOUBLE_RATE      10
`define FLD_MODE_HI          9
`define FLD_MODE_LO          8
`define FLD_COLL_TEST        7
`define FLD_CLK_DIR          6
`define FLD_CLK_DRIVE        5
`define FLD_SPD_HI           4
`define FLD_SPD_LO           2
`define FLD_HEARTBEAT_OFF    0
`define WRITE_MASK           16'h44E1

// ****************************************************************
// Encodings and reset values
// ****************************************************************
`define MODE_MII_MAC         2'h0
`define MODE_MII_PHY         2'h1
`define MODE_RMII_PHY        2'h2
`define SPD_10_HALF          3'h1
`define SPD_100_HALF         3'h2
`define SPD_10_FULL          3'h5
`define SPD_100_FULL         3'h6
`define LOOPBACK_RESET       1'h0
`define COLL_TEST_RESET      1'h0

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS        20
`define SYNC_STAGES          2

`endif

//--- emulated_phy_special_properties.sv
/* Port checker for the emulated PHY special register block.
   Bound to every instance; assumes inputs hold still around a read. */
`timescale 1ns/1ps
`include "emulated_phy_special_regs.vh"
`default_nettype none
module emulated_phy_special_properties #(parameter DATA_W = 4) (
	input wire logic              clk,
	input wire logic              rst_n,
	input wire logic              ce,
	input wire logic [11:0]       csr_addr,
	input wire logic              csr_rd,
	input wire logic [31:0]       csr_rdata,
	input wire logic              csr_rvalid,
	input wire logic              fabric_tx_en,
	input wire logic [DATA_W-1:0] fabric_txd,
	input wire logic              fabric_rx_dv,
	input wire logic [DATA_W-1:0] fabric_rxd,
	input wire logic              fabric_col,
	input wire logic              refclk_out,
	input wire logic              refclk_oe_n,
	input wire logic              drive_16ma,
	input wire logic              rate_200,
	input wire logic              heartbeat_test_en
);
	// ********************
	// Properties
	// ********************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Unmapped reads answer zero, so field checks only look at answers that hit
	logic rd_hit;
	always @(posedge clk) begin
		if (!rst_n) begin
			rd_hit <= 1'b0;
		end else if (ce) begin
			rd_hit <= csr_rd && (csr_addr == `SPECIAL_CSR_OFFSET);
		end
	end
	sequence s_read; ce && csr_rd; endsequence
	sequence s_answer; csr_rvalid && rd_hit; endsequence
	sequence s_loop_seen; ce && csr_rvalid && csr_rdata[14] && fabric_tx_en; endsequence
	property p_rv; s_read |=> csr_rvalid; endproperty
	a_rv: assert property (p_rv) else $error("read not answered");
	property p_resv; csr_rvalid |-> (csr_rdata & 32'hFFFFB802) == 32'h0; endproperty
	a_resv: assert property (p_resv) else $error("reserved bits set");
	property p_miss; csr_rvalid && !rd_hit |-> csr_rdata == 32'h0000_0000; endproperty
	a_miss: assert property (p_miss) else $error("unmapped read not zero");
	property p_mode; s_answer |-> csr_rdata[9:8] != 2'h3; endproperty
	a_mode: assert property (p_mode) else $error("mode reserved");
	property p_spd; s_answer |-> csr_rdata[3] != csr_rdata[2]; endproperty
	a_spd: assert property (p_spd) else $error("speed code reserved");
	property p_col; $past(ce) && fabric_col |-> $past(fabric_tx_en); endproperty
	a_col: assert property (p_col) else $error("collision without transmit");
	property p_loop; s_loop_seen |=> fabric_rx_dv && fabric_rxd == $past(fabric_txd); endproperty
	a_loop: assert property (p_loop) else $error("loopback lost");
	property p_oe; s_answer |-> refclk_oe_n == !csr_rdata[6]; endproperty
	a_oe: assert property (p_oe) else $error("clock direction wrong");
	property p_refclk; ce |=> refclk_out != $past(refclk_out); endproperty
	a_refclk: assert property (p_refclk) else $error("reference clock stalled");
	property p_rate; s_answer |-> rate_200 == (csr_rdata[10] && csr_rdata[3]); endproperty
	a_rate: assert property (p_rate) else $error("rate wrong");
	property p_heart; s_answer |-> heartbeat_test_en == (csr_rdata[9:8] == 2'h1 && !csr_rdata[0]);
	endproperty
	a_heart: assert property (p_heart) else $error("heartbeat wrong");
	property p_drive; s_answer |-> drive_16ma == (csr_rdata[5] && (csr_rdata[9:8] == 2'h2
		|| (csr_rdata[9:8] == 2'h1 && rate_200))); endproperty
	a_drive: assert property (p_drive) else $error("drive wrong");
endmodule // emulated_phy_special_properties
bind emulated_phy_special emulated_phy_special_properties #(.DATA_W(DATA_W)) u_props (
	.clk(clk), .rst_n(rst_n), .ce(ce), .csr_addr(csr_addr), .csr_rd(csr_rd),
	.csr_rdata(csr_rdata), .csr_rvalid(csr_rvalid), .fabric_tx_en(fabric_tx_en),
	.fabric_txd(fabric_txd), .fabric_rx_dv(fabric_rx_dv), .fabric_rxd(fabric_rxd),
	.fabric_col(fabric_col), .refclk_out(refclk_out), .refclk_oe_n(refclk_oe_n),
	.drive_16ma(drive_16ma), .rate_200(rate_200), .heartbeat_test_en(heartbeat_test_en)
);
`default_nettype wire

//--- mac_partner.sv
/* External MAC model on port 0.
   Assumes the device samples link_clk with its own clock. */
`timescale 1ns/1ps
`default_nettype none
module mac_partner (
	input  wire logic       en,
	output var  logic       link_clk,
	output var  logic       mac_tx_en,
	output var  logic [3:0] mac_txd
);
	// ********************
	// Transmit side
	// ********************
	initial link_clk = 1'b0;
	// Free running, as an MII transmit clock is
	always #80 link_clk = ~link_clk;
	// Idle data keeps flipping so stale values never look valid
	always @(negedge link_clk) begin
		mac_tx_en <= en;
		mac_txd <= en ? mac_txd + 4'h1 : ~mac_txd;
	end
	initial mac_txd = 4'h0;
	initial mac_tx_en = 1'b0;
endmodule // mac_partner
`default_nettype wire

//--- tb_top.sv
/* Self-checking bench for the emulated PHY special register.
   Assumes the design header and a 50 MHz clock. */
`timescale 1ns/1ps
`include "emulated_phy_special_regs.vh"
`default_nettype none
module tb_top;
	// ********************
	// Stimulus and checks
	// ********************
	logic clk = 0, rst_n = 0, ce = 1, refclk_in = 0, hold = 0, pen = 0, e, m;
	logic double_rate_strap = 0, clock_direction_strap = 0, clock_drive_strap = 0;
	logic heartbeat_disable_strap = 0, emulated_phy_isolate = 0, emulated_autoneg_enable = 0;
	logic emulated_speed_select = 0, emulated_duplex_mode = 0, autoneg_speed_100 = 0;
	logic autoneg_full_duplex = 0, emulated_phy_reset_bit = 0, vphy_reset_pulse = 0;
	logic csr_wr = 0, csr_rd = 0, mgmt_wr = 0, mgmt_rd = 0, fabric_tx_en = 0;
	logic [1:0] port0_mode_straps = 0, cap;
	logic [11:0] csr_addr = 0;
	logic [4:0] mgmt_index = 0;
	logic [31:0] csr_wdata = 0, csr_rdata, q, d;
	logic [15:0] mgmt_wdata = 0, mgmt_rdata, mr;
	logic [3:0] fabric_txd = 0, fabric_rxd, mac_txd, mac_rxd, t;
	logic csr_rvalid, mgmt_rvalid, fabric_rx_dv, fabric_col, link_clk, mac_tx_en, mac_rx_dv;
	logic refclk_out, refclk_oe_n, drive_16ma, rate_200, heartbeat_test_en;
	int fail_count = 0, checked = 0, cycles = 0, i;
	emulated_phy_special u_dut (
		.clk(clk), .rst_n(rst_n), .ce(ce), .double_rate_strap(double_rate_strap),
		.port0_mode_straps(port0_mode_straps), .clock_direction_strap(clock_direction_strap),
		.clock_drive_strap(clock_drive_strap), .heartbeat_disable_strap(heartbeat_disable_strap),
		.emulated_phy_isolate(emulated_phy_isolate),
		.emulated_autoneg_enable(emulated_autoneg_enable),
		.emulated_speed_select(emulated_speed_select), .emulated_duplex_mode(emulated_duplex_mode),
		.autoneg_speed_100(autoneg_speed_100), .autoneg_full_duplex(autoneg_full_duplex),
		.emulated_phy_reset_bit(emulated_phy_reset_bit), .vphy_reset_pulse(vphy_reset_pulse),
		.csr_addr(csr_addr), .csr_wr(csr_wr), .csr_rd(csr_rd), .csr_wdata(csr_wdata),
		.csr_rdata(csr_rdata), .csr_rvalid(csr_rvalid), .mgmt_index(mgmt_index),
		.mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
		.mgmt_rvalid(mgmt_rvalid), .fabric_tx_en(fabric_tx_en), .fabric_txd(fabric_txd),
		.fabric_rx_dv(fabric_rx_dv), .fabric_rxd(fabric_rxd), .fabric_col(fabric_col),
		.link_clk(link_clk), .mac_tx_en(mac_tx_en), .mac_txd(mac_txd), .mac_rx_dv(mac_rx_dv),
		.mac_rxd(mac_rxd), .refclk_in(refclk_in), .refclk_out(refclk_out),
		.refclk_oe_n(refclk_oe_n), .drive_16ma(drive_16ma), .rate_200(rate_200),
		.heartbeat_test_en(heartbeat_test_en)
	);
	mac_partner u_mac (.en(pen), .link_clk(link_clk), .mac_tx_en(mac_tx_en), .mac_txd(mac_txd));
	initial forever #10 clk = ~clk;
	always @(posedge clk) begin
		fabric_tx_en <= hold | 1'($urandom);
		fabric_txd <= hold ? 4'hA : 4'($urandom);
		cycles++;
		if (cycles == 6000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	function logic [11:0] adr(input logic mg);
		adr = mg ? {7'h0, `SPECIAL_MII_INDEX} : `SPECIAL_CSR_OFFSET;
	endfunction
	function logic [31:0] expv(input logic [15:0] r);
		expv = {16'h0, r};
		expv[4:2] = emulated_autoneg_enable ? {autoneg_full_duplex, autoneg_speed_100,
			!autoneg_speed_100} : {emulated_duplex_mode, emulated_speed_select, !emulated_speed_select};
	endfunction
	task acc(input logic mg, input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk);
		{mgmt_wr, mgmt_rd, csr_wr, csr_rd} <= {mg & w, mg & !w, !mg & w, !mg & !w};
		{mgmt_index, mgmt_wdata, csr_addr, csr_wdata} <= {a[4:0], wd[15:0], a, wd};
		@(posedge clk);
		{mgmt_wr, mgmt_rd, csr_wr, csr_rd} <= 4'h0;
		#1 q = mg ? {16'h0, mgmt_rdata} : csr_rdata;
		if (!w) chk(mg ? mgmt_rvalid : csr_rvalid, 1'b1);
	endtask
	task rdc(input logic mg, input logic [31:0] exp);
		acc(mg, 0, adr(mg), 0);
		chk(q, exp);
	endtask
	task pulse(input logic b);
		@(posedge clk);
		{emulated_phy_reset_bit, vphy_reset_pulse} <= {b, 1'b1};
		@(posedge clk);
		vphy_reset_pulse <= 1'b0;
		cyc(2);
	endtask
	task rst;
		@(posedge clk);
		rst_n <= 1'b0;
		{double_rate_strap, clock_direction_strap, clock_drive_strap} <= 3'($urandom);
		{heartbeat_disable_strap, port0_mode_straps} <= {1'($urandom), 2'($urandom % 3)};
		cyc(4);
		rst_n <= 1'b1;
		cyc(2);
		mr = {5'h0, double_rate_strap, port0_mode_straps, 1'b0, clock_direction_strap,
			clock_drive_strap, 4'h0, heartbeat_disable_strap};
		cap = mr[6:5];
		// Late strap changes must not reach the register
		{double_rate_strap, clock_direction_strap, clock_drive_strap} <= 3'($urandom);
	endtask
	initial begin
		void'($urandom(83090));
		rst();
		rdc(0, expv(mr));
		rdc(1, expv(mr));
		acc(0, 1, 12'h1D8, 32'hFFFFFFFF);
		acc(0, 0, 12'h1D8, 0);
		chk(q, 0);
		acc(1, 0, 12'h01E, 0);
		chk(q, 0);
		rdc(0, expv(mr));
		$display("test map done");
		for (i = 0; i < 40; i++) begin
			@(posedge clk);
			{emulated_phy_isolate, emulated_autoneg_enable, emulated_speed_select} <= 3'($urandom);
			{emulated_duplex_mode, autoneg_speed_100, autoneg_full_duplex} <= 3'($urandom);
			m = 1'($urandom);
			d = (i < 2) ? {32{i[0]}} : $urandom;
			d[7] = d[7] & d[14];
			acc(m, 1, adr(m), d);
			mr = (mr & ~`WRITE_MASK) | (d[15:0] & `WRITE_MASK);
			rdc(!m, expv(mr));
		end
		$display("test random done");
		mr = mr ^ 16'h0060;
		acc(0, 1, adr(0), {16'h0, mr});
		pulse(0);
		rdc(0, expv(mr));
		pulse(1);
		mr[6:5] = cap;
		rdc(1, expv(mr));
		$display("test phy reset done");
		// A write offered while the clock enable is low must not land
		@(posedge clk);
		ce <= 1'b0;
		acc(0, 1, adr(0), {16'h0, mr ^ 16'h4000});
		@(posedge clk);
		ce <= 1'b1;
		rdc(0, expv(mr));
		$display("test clock enable done");
		acc(0, 1, adr(0), 32'h4080);
		repeat (8) begin
			@(posedge clk);
			emulated_phy_isolate <= 1'b1;
			#1 {e, t} = {fabric_tx_en, fabric_txd};
			@(posedge clk);
			#1 chk({fabric_rx_dv, fabric_col, fabric_rxd}, {e, e, t});
		end
		@(posedge clk);
		{emulated_phy_isolate, hold, pen} <= 3'h3;
		acc(0, 1, adr(0), 0);
		cyc(30);
		#1 chk({mac_rx_dv, mac_rxd, fabric_rx_dv}, {1'b1, 4'hA, 1'b1});
		$display("test datapath done");
		rst();
		rdc(0, expv(mr));
		$display("test second reset done");
		tally_and_finish();
	end
endmodule // tb_top
`default_nettype wire
